// ===== dlbp_policer.sv
/*
  Dual leaky bucket policer: meters frames against a committed and
  an excess bucket and gives a colour verdict one cycle later.
  Assumes frames arrive as single-cycle requests on frame_in and
  that software programs the buckets per the coupling flag.
*/
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module dlbp_policer (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire dlbp_pkg::dlbp_frame_t frame_in,
  output dlbp_pkg::dlbp_verdict_t verdict_out
);
  localparam int LW = dlbp_pkg::LVL_W;

  // ==========================================================
  // Helpers
  function automatic logic [LW-1:0] thr_bytes(input logic [6:0] t);
    thr_bytes = LW'({t, 11'h000});
  endfunction

  function automatic logic [LW-1:0] drain_amt(input logic [10:0] r,
                                              input logic [1:0] g);
    drain_amt = LW'(r) << (int'(g) * dlbp_pkg::GRAN_SHIFT);
  endfunction

  function automatic logic [LW-1:0] sat_sub(input logic [LW-1:0] a,
                                            input logic [LW-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction

  // ==========================================================
  // Configuration state
  logic [1:0] gran;
  logic [1:0] ceil;
  logic couple;
  logic [1:0] inc;
  logic [6:0] adj;
  logic [1:0] tsel;
  logic [6:0] thr0;
  logic [6:0] thr1;
  logic [10:0] rate0;
  logic [10:0] rate1;
  logic drain_en;
  logic fill_en;
  logic [15:0] tick_per;
  logic [3:0] flags;
  logic [LW-1:0] lvl0;
  logic [LW-1:0] lvl1;
  logic tick;

  logic wr_setup;
  logic wr_flags;
  assign wr_setup = reg_wr_in && reg_addr_in == dlbp_pkg::OFS_SETUP;
  assign wr_flags = reg_wr_in && reg_addr_in == dlbp_pkg::OFS_FLAGS;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      gran <= 2'h0;
      ceil <= dlbp_pkg::RST_CEIL;
      couple <= 1'b0;
      inc <= 2'h0;
      adj <= 7'h00;
      tsel <= dlbp_pkg::RST_TSEL;
    end else if (wr_setup) begin
      gran <= reg_wdata_in[dlbp_pkg::POS_GRAN +: 2];
      ceil <= reg_wdata_in[dlbp_pkg::POS_CEIL +: 2];
      couple <= reg_wdata_in[dlbp_pkg::POS_COUPLE];
      inc <= reg_wdata_in[dlbp_pkg::POS_INC +: 2];
      adj <= reg_wdata_in[dlbp_pkg::POS_ADJ +: 7];
      tsel <= reg_wdata_in[dlbp_pkg::POS_TSEL +: 2];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      thr0 <= 7'h00;
      rate0 <= 11'h000;
    end else if (reg_wr_in && reg_addr_in == dlbp_pkg::OFS_BUCKET0) begin
      thr0 <= reg_wdata_in[dlbp_pkg::POS_THR +: 7];
      rate0 <= reg_wdata_in[dlbp_pkg::POS_RATE +: 11];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      thr1 <= 7'h00;
      rate1 <= 11'h000;
    end else if (reg_wr_in && reg_addr_in == dlbp_pkg::OFS_BUCKET1) begin
      thr1 <= reg_wdata_in[dlbp_pkg::POS_THR +: 7];
      rate1 <= reg_wdata_in[dlbp_pkg::POS_RATE +: 11];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      drain_en <= 1'b0;
      fill_en <= 1'b0;
      tick_per <= dlbp_pkg::RST_TICK;
    end else if (reg_wr_in && reg_addr_in == dlbp_pkg::OFS_GLOBAL) begin
      drain_en <= reg_wdata_in[dlbp_pkg::POS_DRAIN_EN];
      fill_en <= reg_wdata_in[dlbp_pkg::POS_FILL_EN];
      tick_per <= reg_wdata_in[dlbp_pkg::POS_TICK +: 16];
    end
  end

  // ==========================================================
  // Base tick
  dlbp_tick_div u_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(drain_en),
    .period_in(tick_per),
    .tick_out(tick)
  );

  // ==========================================================
  // Classification
  logic run;
  logic sel_hit;
  logic policed;
  logic in_green;
  logic conform0;
  logic conform1;
  logic go_green;
  logic go_yel;
  logic drop;
  logic [15:0] sz_raw;
  logic [LW-1:0] fsize;
  logic [2:0] dl_sum;
  logic [1:0] inc_level;

  assign run = drain_en && fill_en;
  assign sel_hit = (frame_in.to_cpu && tsel[0]) ||
                   (frame_in.to_front && tsel[1]);
  assign policed = frame_in.valid && sel_hit && run;
  assign in_green = frame_in.drop_level <= ceil;
  assign conform0 = lvl0 < thr_bytes(thr0);
  assign conform1 = lvl1 < thr_bytes(thr1);
  assign go_green = in_green && conform0;
  assign go_yel = !go_green && conform1;
  assign drop = !go_green && !conform1;
  assign sz_raw = {2'b00, frame_in.length} + {{9{adj[6]}}, adj};
  assign fsize = sz_raw[15] ? '0 : LW'(sz_raw[14:0]);
  assign dl_sum = {1'b0, frame_in.drop_level} + {1'b0, inc};
  assign inc_level = dl_sum[2] ? dlbp_pkg::DROP_MAX : dl_sum[1:0];

  // ==========================================================
  // Bucket levels
  logic [LW-1:0] fill0;
  logic [LW-1:0] fill1;
  logic [LW-1:0] next_lvl0;
  logic [LW-1:0] next_lvl1;
  logic drain_now;

  assign drain_now = tick && drain_en;
  assign fill0 = (policed && go_green) ? fsize : '0;
  assign fill1 = (policed && (go_yel || (go_green && couple))) ?
                 fsize : '0;
  assign next_lvl0 = (drain_now ? sat_sub(lvl0, drain_amt(rate0, gran))
                                : lvl0) + fill0;
  assign next_lvl1 = (drain_now ? sat_sub(lvl1, drain_amt(rate1, gran))
                                : lvl1) + fill1;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lvl0 <= '0;
      lvl1 <= '0;
    end else begin
      lvl0 <= next_lvl0;
      lvl1 <= next_lvl1;
    end
  end

  // ==========================================================
  // Verdict
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      verdict_out <= '0;
    end else begin
      verdict_out.valid <= frame_in.valid;
      verdict_out.policed <= policed;
      verdict_out.yellow <= policed ? go_yel : !in_green;
      verdict_out.discard <= policed && drop;
      verdict_out.drop_level <= (policed && go_yel) ? inc_level
                                : frame_in.drop_level;
    end
  end

  // ==========================================================
  // Sticky flags, set wins over clear
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  always_comb begin
    flag_set = 4'h0;
    flag_set[dlbp_pkg::FLG_DISCARD] = policed && drop;
    flag_set[dlbp_pkg::FLG_OPEN] = policed && go_green && conform1;
    flag_set[dlbp_pkg::FLG_COMMIT] = policed && !conform0;
    flag_set[dlbp_pkg::FLG_PEAK] = policed && !go_green &&
                                   !conform1;
  end
  assign flag_clr = wr_flags ? reg_wdata_in[3:0] : 4'h0;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ==========================================================
  // Register reads
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        dlbp_pkg::OFS_SETUP: begin
          reg_rdata_out <= {16'h0000, tsel, adj, inc, couple, ceil, gran};
        end
        dlbp_pkg::OFS_BUCKET0: begin
          reg_rdata_out <= {13'h0000, rate0, 1'b0, thr0};
        end
        dlbp_pkg::OFS_BUCKET1: begin
          reg_rdata_out <= {13'h0000, rate1, 1'b0, thr1};
        end
        dlbp_pkg::OFS_GLOBAL: begin
          reg_rdata_out <= {12'h000, tick_per, 2'h0, fill_en, drain_en};
        end
        dlbp_pkg::OFS_FLAGS: begin
          reg_rdata_out <= {28'h0000000, flags};
        end
        dlbp_pkg::OFS_LEVEL0: begin
          reg_rdata_out <= 32'(lvl0);
        end
        dlbp_pkg::OFS_LEVEL1: begin
          reg_rdata_out <= 32'(lvl1);
        end
        default: begin
          reg_rdata_out <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_green;
    policed && go_green |=> verdict_out.valid && !verdict_out.yellow &&
      !verdict_out.discard;
  endproperty
  a_green: assert property (p_green)
    else $error("conforming green frame not passed green");

  property p_blind;
    policed && ceil == dlbp_pkg::COLOR_BLIND && conform0 |=>
      !verdict_out.yellow && !verdict_out.discard;
  endproperty
  a_blind: assert property (p_blind)
    else $error("colour-blind frame not green");

  property p_ceiling;
    policed && frame_in.drop_level > ceil |=> !verdict_out.policed ||
      verdict_out.yellow || verdict_out.discard;
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("frame above ceiling treated green");

  property p_increment;
    policed && go_yel && frame_in.drop_level == 2'h0 |=>
      verdict_out.drop_level == $past(inc);
  endproperty
  a_increment: assert property (p_increment)
    else $error("drop level increment wrong");

  property p_discard;
    policed && drop |=> verdict_out.discard &&
      flags[dlbp_pkg::FLG_DISCARD] && flags[dlbp_pkg::FLG_PEAK];
  endproperty
  a_discard: assert property (p_discard)
    else $error("discard not flagged");

  property p_unselected;
    frame_in.valid && !sel_hit |=> verdict_out.valid &&
      !verdict_out.policed && !verdict_out.discard;
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("unselected frame was policed");

  property p_enables;
    frame_in.valid && !(drain_en && fill_en) |=> !verdict_out.policed &&
      ($stable(lvl0) || $past(drain_now));
  endproperty
  a_enables: assert property (p_enables)
    else $error("policing while disabled");

  property p_floor;
    drain_now && !policed && lvl0 <= drain_amt(rate0, gran) |=> lvl0 == '0;
  endproperty
  a_floor: assert property (p_floor)
    else $error("bucket did not drain to zero");

  property p_sticky;
    flags[dlbp_pkg::FLG_COMMIT] &&
      !(wr_flags && reg_wdata_in[dlbp_pkg::FLG_COMMIT]) |=>
      flags[dlbp_pkg::FLG_COMMIT];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky flag lost without clear");

  property p_open;
    policed && go_green && conform1 |=> flags[dlbp_pkg::FLG_OPEN];
  endproperty
  a_open: assert property (p_open)
    else $error("both-open flag not set");

  c_yellow: cover property (policed && go_yel ##1 verdict_out.yellow);
  c_discard: cover property (policed && drop);
  c_tick_fill: cover property (drain_now && policed);
  c_coupled: cover property (policed && go_green && couple);
endmodule

// ===== dlbp_pkg.sv
/*
  Shared constants and carriers of the dual leaky bucket policer.
  Assumes a 200 MHz core clock and a 32-bit register port.
*/
package dlbp_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_BUCKET0 = 8'h04;
  localparam logic [7:0] OFS_BUCKET1 = 8'h08;
  localparam logic [7:0] OFS_GLOBAL = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_LEVEL0 = 8'h14;
  localparam logic [7:0] OFS_LEVEL1 = 8'h18;
  // ==========================================================
  // Field positions
  localparam int POS_GRAN = 0;
  localparam int POS_CEIL = 2;
  localparam int POS_COUPLE = 4;
  localparam int POS_INC = 5;
  localparam int POS_ADJ = 7;
  localparam int POS_TSEL = 14;
  localparam int POS_THR = 0;
  localparam int POS_RATE = 8;
  localparam int POS_DRAIN_EN = 0;
  localparam int POS_FILL_EN = 1;
  localparam int POS_TICK = 4;
  localparam int FLG_DISCARD = 0;
  localparam int FLG_OPEN = 1;
  localparam int FLG_COMMIT = 2;
  localparam int FLG_PEAK = 3;
  // ==========================================================
  // Widths and scaling
  localparam int LVL_W = 21;
  localparam int THR_SHIFT = 11;
  localparam int GRAN_SHIFT = 3;
  localparam logic [1:0] COLOR_BLIND = 2'h3;
  localparam logic [1:0] DROP_MAX = 2'h3;
  // ==========================================================
  // Values after reset
  localparam logic [1:0] RST_CEIL = 2'h3;
  localparam logic [1:0] RST_TSEL = 2'h3;
  localparam logic [15:0] RST_TICK = 16'h0028;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [13:0] length;
    logic [1:0] drop_level;
    logic to_cpu;
    logic to_front;
  } dlbp_frame_t;
  typedef struct packed {
    logic valid;
    logic policed;
    logic yellow;
    logic discard;
    logic [1:0] drop_level;
  } dlbp_verdict_t;
endpackage

// ===== dlbp_tick_div.sv
/*
  Base tick divider: one-cycle pulse every period cycles.
  Assumes period is steady while enabled; zero acts as one.
*/
`timescale 1ns/1ps
module dlbp_tick_div (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic [15:0] period_in,
  output logic tick_out
);
  logic [15:0] count;

  // ==========================================================
  // Counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !enable_in) begin
      count <= 16'h0000;
      tick_out <= 1'b0;
    end else if (count + 16'h0001 >= period_in) begin
      count <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick_out <= 1'b0;
    end
  end
endmodule

// ===== dlbp_feed_model.sv
/*
  Frame pipeline model: issues single-cycle requests to the policer
  and keeps the last verdict. Assumes requests are spaced apart.
*/
`timescale 1ns/1ps
module dlbp_feed_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic send_in,
  input wire dlbp_pkg::dlbp_frame_t req_in,
  output dlbp_pkg::dlbp_frame_t frame_out,
  input wire dlbp_pkg::dlbp_verdict_t verdict_in,
  output dlbp_pkg::dlbp_verdict_t seen_out,
  output logic slip_out
);
  logic waiting;
  // ==========================================================
  // Request side, idle fields toggle every cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      frame_out <= '0;
    end else if (send_in) begin
      frame_out <= {1'b1, req_in[17:0]};
    end else begin
      frame_out <= {1'b0, ~frame_out[17:0]};
    end
  end
  // ==========================================================
  // Answer side, verdict due one cycle after request
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      waiting <= 1'b0;
      seen_out <= '0;
      slip_out <= 1'b0;
    end else begin
      waiting <= frame_out.valid;
      if (frame_out.valid) begin
        seen_out <= '0;
      end else if (verdict_in.valid) begin
        seen_out <= verdict_in;
      end
      if (waiting != verdict_in.valid) begin
        slip_out <= 1'b1;
      end
    end
  end
endmodule

// ===== testbench.sv
/*
  Self-checking bench of the policer: register port tasks and
  frame scenarios. Assumes the pipeline model beside it.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic send = 1'b0;
  dlbp_pkg::dlbp_frame_t req = '0;
  dlbp_pkg::dlbp_frame_t frame_in;
  dlbp_pkg::dlbp_verdict_t verdict_out;
  dlbp_pkg::dlbp_verdict_t seen;
  logic slip;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2.5 clk_in = ~clk_in;
  dlbp_policer i_dlbp_policer (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .frame_in(frame_in),
    .verdict_out(verdict_out));
  dlbp_feed_model i_dlbp_feed_model (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .send_in(send), .req_in(req),
    .frame_out(frame_in), .verdict_in(verdict_out), .seen_out(seen),
    .slip_out(slip));
  // ==========================================================
  // Field packing
  function automatic logic [31:0] sw(input logic [1:0] g, c,
    input logic cp, input logic [1:0] inc, input logic [6:0] adj,
    input logic [1:0] ts);
    sw = {16'h0, ts, adj, inc, cp, c, g};
  endfunction
  function automatic logic [31:0] bw(input logic [10:0] r,
    input logic [6:0] t);
    bw = {13'h0, r, 1'b0, t};
  endfunction
  // ==========================================================
  // Compare and bus tasks
  task automatic chk_word(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_verdict(input string what, input logic [5:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd_get(input logic [7:0] a);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    rd = reg_rdata_out;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    rd_get(a);
    chk_word(what, exp, rd);
  endtask
  task automatic frame(input string what, input logic [13:0] len,
    input logic [1:0] dp, input logic cpu, front, input logic [4:0] exp);
    @(posedge clk_in);
    send <= 1'b1;
    req <= '{1'b1, len, dp, cpu, front};
    @(posedge clk_in);
    send <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk_verdict(what, {1'b1, exp});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk("setup", dlbp_pkg::OFS_SETUP, 32'h0000c00c);
    rd_chk("global", dlbp_pkg::OFS_GLOBAL, 32'h00000280);
    rd_chk("flags", dlbp_pkg::OFS_FLAGS, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd_chk("unmapped", 8'h1c, 32'h0);
    frame("disabled", 14'd100, 2'h0, 1'b1, 1'b1, 5'h00);
    rd_chk("idle level", dlbp_pkg::OFS_LEVEL0, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_meter();
    wr(dlbp_pkg::OFS_SETUP, sw(2'h0, 2'h1, 1'b0, 2'h1, 7'h3f, 2'h3));
    wr(dlbp_pkg::OFS_BUCKET0, bw(11'h0, 7'h01));
    wr(dlbp_pkg::OFS_BUCKET1, bw(11'h0, 7'h01));
    wr(dlbp_pkg::OFS_GLOBAL, 32'h00000043);
    frame("green a", 14'd937, 2'h0, 1'b1, 1'b0, 5'h10);
    rd_chk("adjusted", dlbp_pkg::OFS_LEVEL0, 32'd1000);
    frame("green b", 14'd1437, 2'h0, 1'b1, 1'b0, 5'h10);
    rd_chk("open", dlbp_pkg::OFS_FLAGS, 32'h2);
    frame("yellow a", 14'd37, 2'h0, 1'b0, 1'b1, 5'h19);
    frame("yellow b", 14'd1937, 2'h0, 1'b0, 1'b1, 5'h19);
    frame("discard", 14'd37, 2'h3, 1'b0, 1'b1, 5'h17);
    wr(dlbp_pkg::OFS_LEVEL0, 32'h0);
    rd_chk("level0", dlbp_pkg::OFS_LEVEL0, 32'd2500);
    rd_chk("level1", dlbp_pkg::OFS_LEVEL1, 32'd2100);
    rd_chk("all flags", dlbp_pkg::OFS_FLAGS, 32'hf);
    wr(dlbp_pkg::OFS_FLAGS, 32'h1);
    rd_chk("one cleared", dlbp_pkg::OFS_FLAGS, 32'he);
    wr(dlbp_pkg::OFS_FLAGS, 32'hf);
    rd_chk("all cleared", dlbp_pkg::OFS_FLAGS, 32'h0);
    $display("test meter done");
  endtask
  task automatic t_drain();
    wr(dlbp_pkg::OFS_SETUP, sw(2'h1, 2'h1, 1'b0, 2'h1, 7'h3f, 2'h3));
    wr(dlbp_pkg::OFS_BUCKET0, bw(11'h008, 7'h01));
    repeat (38) @(posedge clk_in);
    wr(dlbp_pkg::OFS_BUCKET0, bw(11'h000, 7'h01));
    rd_chk("steps", dlbp_pkg::OFS_LEVEL0, 32'd1860);
    rd_chk("level1 kept", dlbp_pkg::OFS_LEVEL1, 32'd2100);
    wr(dlbp_pkg::OFS_SETUP, sw(2'h3, 2'h1, 1'b0, 2'h1, 7'h3f, 2'h3));
    wr(dlbp_pkg::OFS_BUCKET0, bw(11'h7ff, 7'h01));
    wr(dlbp_pkg::OFS_BUCKET1, bw(11'h7ff, 7'h01));
    repeat (10) @(posedge clk_in);
    wr(dlbp_pkg::OFS_BUCKET0, bw(11'h0, 7'h01));
    wr(dlbp_pkg::OFS_BUCKET1, bw(11'h0, 7'h01));
    rd_chk("floor0", dlbp_pkg::OFS_LEVEL0, 32'h0);
    rd_chk("floor1", dlbp_pkg::OFS_LEVEL1, 32'h0);
    $display("test drain done");
  endtask
  task automatic t_coupled();
    wr(dlbp_pkg::OFS_SETUP, sw(2'h0, 2'h1, 1'b1, 2'h2, 7'h3f, 2'h3));
    frame("at ceiling", 14'd437, 2'h1, 1'b1, 1'b0, 5'h11);
    frame("above", 14'd37, 2'h2, 1'b1, 1'b0, 5'h1b);
    rd_chk("c level0", dlbp_pkg::OFS_LEVEL0, 32'd500);
    rd_chk("c level1", dlbp_pkg::OFS_LEVEL1, 32'd600);
    $display("test coupled done");
  endtask
  task automatic t_select();
    wr(dlbp_pkg::OFS_SETUP, sw(2'h0, 2'h3, 1'b1, 2'h1, 7'h40, 2'h1));
    frame("front only", 14'd37, 2'h3, 1'b0, 1'b1, 5'h03);
    frame("cpu blind", 14'd100, 2'h3, 1'b1, 1'b0, 5'h13);
    rd_chk("neg adjust", dlbp_pkg::OFS_LEVEL0, 32'd536);
    $display("test select done");
  endtask
  // ==========================================================
  // Run control
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_meter();
    t_drain();
    t_coupled();
    t_select();
    chk_word("verdict timing", 32'h0, {31'h0, slip});
    wrap_up();
  end
endmodule
